// ---- hw/mmr_pkg.sv ----
/*
 * Constants of the motor measurement register bank: register indices,
 * field positions, reset values and conditioning figures.
 * Assumes word-aligned APB access; byte address is four times the index.
 */
package mmr_pkg;
    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_PHASE_U = 10'h07a;
    localparam logic [9:0] IDX_PHASE_V = 10'h07b;
    localparam logic [9:0] IDX_PHASE_W = 10'h07c;
    localparam logic [9:0] IDX_ALPHA = 10'h07e;
    localparam logic [9:0] IDX_BETA = 10'h07f;
    localparam logic [9:0] IDX_VBUS = 10'h088;
    localparam logic [9:0] IDX_CTRL = 10'h090;

    // ------------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_GAIN_LSB = 16;
    localparam logic [15:0] MEAS_RESET = 16'h0000;
    localparam logic CTRL_MODE_RESET = 1'b0;
    localparam logic [15:0] CTRL_GAIN_RESET = 16'h1000;

    // ------------------------------------------------------------------
    // Conditioning figures
    // ------------------------------------------------------------------
    localparam int GAIN_SHIFT = 12;
    localparam logic signed [15:0] CUR_MAX = 16'sh07ff;
    localparam logic signed [15:0] CUR_MIN = -16'sh07ff;
    localparam logic [15:0] VBUS_MAX = 16'h0fff;
    // 1/sqrt(3) in Q15
    localparam logic signed [17:0] INV_SQRT3 = 18'sh049e7;
    localparam int INV_SQRT3_SHIFT = 15;

    typedef enum logic [0:0] {
        MMR_LEG_SHUNT = 1'b0,
        MMR_SINGLE_SHUNT = 1'b1
    } mmr_shunt_type;
endpackage : mmr_pkg

// ---- hw/mmr_cond.sv ----
/*
 * One current channel: removes sensing offset, applies ADC gain
 * compensation and limits to the signed current range.
 * Assumes raw and offset are unsigned 12-bit ADC codes; purely combinational.
 */
`timescale 1ns/10ps
module mmr_cond (
    input wire logic [11:0] raw,
    input wire logic [11:0] offset,
    input wire logic [15:0] gain,
    output logic signed [15:0] result
);
    // ------------------------------------------------------------------
    // Offset removal and compensation
    // ------------------------------------------------------------------
    wire logic signed [12:0] diff;
    wire logic signed [29:0] prod;
    wire logic signed [17:0] scaled;
    assign diff = $signed({1'b0, raw}) - $signed({1'b0, offset});
    assign prod = 30'(diff * $signed({1'b0, gain}));
    assign scaled = 18'(prod >>> mmr_pkg::GAIN_SHIFT);

    // Clamp keeps a mis-set gain from wrapping the sign
    assign result = (scaled > 18'(mmr_pkg::CUR_MAX)) ? mmr_pkg::CUR_MAX :
                    (scaled < 18'(mmr_pkg::CUR_MIN)) ? mmr_pkg::CUR_MIN :
                    16'(scaled);
endmodule : mmr_cond

// ---- hw/mmr_top.sv ----
/*
 * Motor measurement register bank: phase currents, alpha/beta currents
 * and raw bus voltage, refreshed on each PWM cycle strobe, read over APB.
 * Assumes ADC samples are valid while pwm_cycle is high, inputs are
 * synchronous to pclk, and ce freezes all state while low.
 */
`timescale 1ns/10ps
module mmr_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm_cycle,
    input wire logic [11:0] link_sample_u,
    input wire logic [11:0] link_sample_v,
    input wire logic [11:0] shunt_sample_u,
    input wire logic [11:0] shunt_sample_v,
    input wire logic [11:0] offset_u,
    input wire logic [11:0] offset_v,
    input wire logic [11:0] bus_voltage_adc
);
    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    mmr_pkg::mmr_shunt_type mode_reg;
    logic [15:0] gain_reg;

    // ------------------------------------------------------------------
    // Measurement registers
    // ------------------------------------------------------------------
    logic signed [15:0] phase_u_current_reg;
    logic signed [15:0] phase_v_current_reg;
    logic signed [15:0] phase_w_current_reg;
    logic signed [15:0] alpha_axis_current_reg;
    logic signed [15:0] beta_axis_current_reg;
    logic [15:0] bus_voltage_sample_reg;

    // ------------------------------------------------------------------
    // Channel selection and conditioning
    // ------------------------------------------------------------------
    wire logic single_mode;
    wire logic [11:0] raw_sel [2];
    wire logic [11:0] raw_link [2];
    wire logic [11:0] raw_shunt [2];
    wire logic [11:0] raw_offset [2];
    wire logic signed [15:0] cond_cur [2];
    assign single_mode = (mode_reg == mmr_pkg::MMR_SINGLE_SHUNT);
    assign raw_link[0] = link_sample_u;
    assign raw_link[1] = link_sample_v;
    assign raw_shunt[0] = shunt_sample_u;
    assign raw_shunt[1] = shunt_sample_v;
    assign raw_offset[0] = offset_u;
    assign raw_offset[1] = offset_v;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            // Link current in single shunt, own leg shunt otherwise
            assign raw_sel[ch] = single_mode ? raw_link[ch] :
                                 raw_shunt[ch];
            mmr_cond u_cond (
                .raw(raw_sel[ch]),
                .offset(raw_offset[ch]),
                .gain(gain_reg),
                .result(cond_cur[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Derived currents
    // ------------------------------------------------------------------
    wire logic signed [16:0] uv_sum;
    wire logic signed [16:0] w_raw;
    wire logic signed [15:0] w_next;
    assign uv_sum = 17'(cond_cur[0]) + 17'(cond_cur[1]);
    assign w_raw = -uv_sum;
    // W range would reach 4094 otherwise; keep it within the current range
    assign w_next = (w_raw > 17'(mmr_pkg::CUR_MAX)) ? mmr_pkg::CUR_MAX :
                    (w_raw < 17'(mmr_pkg::CUR_MIN)) ? mmr_pkg::CUR_MIN :
                    16'(w_raw);

    // Clarke transform: alpha = u, beta = (u + 2v) / sqrt(3)
    wire logic signed [17:0] beta_sum;
    wire logic signed [35:0] beta_prod;
    wire logic signed [20:0] beta_raw;
    wire logic signed [15:0] alpha_next;
    wire logic signed [15:0] beta_next;
    assign alpha_next = cond_cur[0];
    assign beta_sum = 18'(cond_cur[0]) + 18'(cond_cur[1]) +
                      18'(cond_cur[1]);
    assign beta_prod = 36'(beta_sum * mmr_pkg::INV_SQRT3);
    assign beta_raw = 21'(beta_prod >>> mmr_pkg::INV_SQRT3_SHIFT);
    assign beta_next = (beta_raw > 21'(mmr_pkg::CUR_MAX)) ? mmr_pkg::CUR_MAX :
                       (beta_raw < 21'(mmr_pkg::CUR_MIN)) ? mmr_pkg::CUR_MIN :
                       16'(beta_raw);

    wire logic [15:0] vbus_next;
    assign vbus_next = {4'h0, bus_voltage_adc};

    // ------------------------------------------------------------------
    // Refresh on the PWM cycle strobe
    // ------------------------------------------------------------------
    wire logic refresh;
    assign refresh = ce & pwm_cycle;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_u_current_reg <= mmr_pkg::MEAS_RESET;
            phase_v_current_reg <= mmr_pkg::MEAS_RESET;
            phase_w_current_reg <= mmr_pkg::MEAS_RESET;
            alpha_axis_current_reg <= mmr_pkg::MEAS_RESET;
            beta_axis_current_reg <= mmr_pkg::MEAS_RESET;
            bus_voltage_sample_reg <= mmr_pkg::MEAS_RESET;
        end else if (refresh) begin
            phase_u_current_reg <= cond_cur[0];
            phase_v_current_reg <= cond_cur[1];
            phase_w_current_reg <= w_next;
            alpha_axis_current_reg <= alpha_next;
            beta_axis_current_reg <= beta_next;
            bus_voltage_sample_reg <= vbus_next;
        end
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire logic [9:0] word_idx;
    wire logic aligned;
    wire logic hit_u;
    wire logic hit_v;
    wire logic hit_w;
    wire logic hit_alpha;
    wire logic hit_beta;
    wire logic hit_vbus;
    wire logic hit_ctrl;
    wire logic mapped;
    wire logic setup;
    wire logic ctrl_write;
    wire logic [31:0] ctrl_word;
    wire logic [31:0] read_word;
    assign word_idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_u = aligned & (word_idx == mmr_pkg::IDX_PHASE_U);
    assign hit_v = aligned & (word_idx == mmr_pkg::IDX_PHASE_V);
    assign hit_w = aligned & (word_idx == mmr_pkg::IDX_PHASE_W);
    assign hit_alpha = aligned & (word_idx == mmr_pkg::IDX_ALPHA);
    assign hit_beta = aligned & (word_idx == mmr_pkg::IDX_BETA);
    assign hit_vbus = aligned & (word_idx == mmr_pkg::IDX_VBUS);
    assign hit_ctrl = aligned & (word_idx == mmr_pkg::IDX_CTRL);
    assign mapped = hit_u | hit_v | hit_w | hit_alpha | hit_beta |
                    hit_vbus | hit_ctrl;
    assign setup = ce & psel & ~penable;
    // Only the control word accepts writes; measurement writes drop
    assign ctrl_write = ce & psel & penable & pwrite & hit_ctrl;
    assign ctrl_word = {gain_reg, 15'h0000, mode_reg};
    // Signed values read sign-extended to the full word
    assign read_word =
        hit_u ? {{16{phase_u_current_reg[15]}}, phase_u_current_reg} :
        hit_v ? {{16{phase_v_current_reg[15]}}, phase_v_current_reg} :
        hit_w ? {{16{phase_w_current_reg[15]}}, phase_w_current_reg} :
        hit_alpha ? {{16{alpha_axis_current_reg[15]}},
                     alpha_axis_current_reg} :
        hit_beta ? {{16{beta_axis_current_reg[15]}},
                    beta_axis_current_reg} :
        hit_vbus ? {16'h0000, bus_voltage_sample_reg} :
        hit_ctrl ? ctrl_word : 32'h00000000;

    // No wait states; the access phase always completes
    assign pready = 1'b1;

    // Read data is captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : read_word;
            pslverr <= ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= mmr_pkg::mmr_shunt_type'(mmr_pkg::CTRL_MODE_RESET);
            gain_reg <= mmr_pkg::CTRL_GAIN_RESET;
        end else if (ctrl_write) begin
            mode_reg <= mmr_pkg::mmr_shunt_type'(
                pwdata[mmr_pkg::CTRL_MODE_BIT]);
            gain_reg <= pwdata[mmr_pkg::CTRL_GAIN_LSB +: 16];
        end
    end
endmodule : mmr_top

// ---- verification/mmr_asserts.sv ----
/* Checker of mmr_top read answers, error answers and read data hold.
   Assumes it is bound to mmr_top and sees only that module's ports. */
`timescale 1ns/10ps
module mmr_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    wire rd = psel && !penable && ce && !pwrite;
    wire wr = psel && !penable && ce && pwrite;
    function automatic bit rng(logic [31:0] d);
        return $signed(d) >= -2047 && $signed(d) <= 2047;
    endfunction : rng
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_cur(logic [11:0] a);
        rd && paddr == a |=> !pslverr && rng(prdata);
    endproperty
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_u_range: assert property (p_cur(12'h1e8))
        else $error("phase u read out of range");
    a_v_range: assert property (p_cur(12'h1ec))
        else $error("phase v read out of range");
    a_w_range: assert property (p_cur(12'h1f0))
        else $error("phase w read out of range");
    a_alpha_range: assert property (p_cur(12'h1f8))
        else $error("alpha read out of range");
    a_beta_range: assert property (p_cur(12'h1fc))
        else $error("beta read out of range");
    a_vbus_range: assert property (rd && paddr == 12'h220 |=>
        !pslverr && prdata[31:12] == 20'h0) else $error("bus voltage wide");
    a_write_quiet: assert property (wr |=> prdata == 32'h0)
        else $error("write returned data");
    a_unaligned_err: assert property (rd && paddr[1:0] != 2'h0 |=>
        pslverr && prdata == 32'h0) else $error("unaligned read accepted");
    a_rd_hold: assert property (rd |=> ##1 $stable(prdata))
        else $error("read data moved before next setup");
    c_beta: cover property (rd && paddr == 12'h1fc);
    c_bad: cover property (rd && paddr[1:0] != 2'h0);
    c_wr_rd: cover property (wr ##3 rd);
endmodule : mmr_asserts

bind mmr_top mmr_asserts u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pslverr(pslverr));

// ---- verification/mmr_top_bench.sv ----
/* Self-checking bench of mmr_top: APB reads against a reference model.
   Assumes mmr_pkg is compiled first and the checker is bound. */
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module mmr_top_bench;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic pwm_cycle = 0, pready, pslverr;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [11:0] paddr = 12'h0, lu = 12'h0, lv = 12'h0, su = 12'h0;
    logic [11:0] sv = 12'h0, ou = 12'h0, ov = 12'h0, vb = 12'h0;
    logic [32:0] exp_q[$], e_now;
    logic [11:0] at[6] = '{12'h1e8, 12'h1ec, 12'h1f0, 12'h1f8, 12'h1fc,
        12'h220};
    int mismatches = 0, checks = 0, seed = 99181, cyc = 0;
    int m[6] = '{0, 0, 0, 0, 0, 0}, gain = 4096, mode = 0;
    mmr_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_cycle(pwm_cycle), .link_sample_u(lu), .link_sample_v(lv),
        .shunt_sample_u(su), .shunt_sample_v(sv), .offset_u(ou),
        .offset_v(ov), .bus_voltage_adc(vb));
    initial forever #50 pclk = ~pclk;
    // ------------------------------------------------------------------
    // Reference model and bus tasks
    // ------------------------------------------------------------------
    function automatic int clamp(int x);
        return x > 2047 ? 2047 : (x < -2047 ? -2047 : x);
    endfunction : clamp
    function automatic int cond(logic [11:0] r, logic [11:0] o);
        return clamp(((int'(r) - int'(o)) * gain) >>> 12);
    endfunction : cond
    task xfer(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk); // Idle edge keeps one assignment per step
    endtask : xfer
    task rd_all;
        for (int i = 0; i < 6; i++) xfer(0, at[i], 32'h0, {1'b0, 32'(m[i])});
    endtask : rd_all
    task refresh(bit en);
        logic [11:0] r[7];
        for (int k = 0; k < 7; k++) r[k] = 12'($random(seed));
        lu <= r[0]; lv <= r[1]; su <= r[2]; sv <= r[3];
        ou <= r[4]; ov <= r[5]; vb <= r[6];
        ce <= en;
        pwm_cycle <= 1;
        @(posedge pclk);
        pwm_cycle <= 0;
        ce <= 1;
        if (en) begin
            m[0] = cond(mode ? r[0] : r[2], r[4]);
            m[1] = cond(mode ? r[1] : r[3], r[5]);
            m[2] = clamp(-(m[0] + m[1]));
            m[3] = m[0];
            m[4] = clamp(((m[0] + 2 * m[1]) *
                int'(mmr_pkg::INV_SQRT3)) >>> 15);
            m[5] = int'(r[6]);
        end
    endtask : refresh
    task final_report;
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------------
    // Monitor and timeout
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready) begin
            e_now = exp_q.pop_front();
            `CHK({pslverr, prdata}, e_now)
        end
        if (cyc > 5000) begin
            mismatches++;
            final_report;
        end
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd_all;
        refresh(1);
        for (int i = 0; i < 6; i++)
            xfer(1, at[i], $random(seed), 33'h0);
        rd_all;
        for (int n = 0; n < 24; n++) begin
            mode = n % 2;
            gain = (n % 3 + 1) * 2048;
            xfer(1, 12'h240, {16'(gain), 15'h0, 1'(mode)}, 33'h0);
            xfer(0, 12'h240, 32'h0,
                {1'b0, 16'(gain), 15'h0, 1'(mode)});
            refresh(n != 5); // Frozen enable must not refresh
            rd_all;
        end
        xfer(0, 12'h1e9, 32'h0, {1'b1, 32'h0});
        xfer(0, 12'h004, 32'h0, {1'b1, 32'h0});
        xfer(1, 12'h004, 32'h5a5a5a5a, {1'b1, 32'h0});
        presetn <= 0; // Mid-run reset must clear the bank again
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        m = '{0, 0, 0, 0, 0, 0};
        rd_all;
        xfer(0, 12'h240, 32'h0, {1'b0, mmr_pkg::CTRL_GAIN_RESET, 15'h0,
            mmr_pkg::CTRL_MODE_RESET});
        final_report;
    end
endmodule : mmr_top_bench
